// ==== pump_map_cfg.svh ====
// Parameter numbers, field positions, reset values and limits of the
// pump driver parameter map.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef PUMP_MAP_CFG_SVH
`define PUMP_MAP_CFG_SVH
// ----------------------------------------------------------------------
// Parameter numbers
// ----------------------------------------------------------------------
`define ADDR_FREQ 16'h0100
`define ADDR_FREQ_MIN 16'h0101
`define ADDR_FREQ_MAX 16'h0102
`define ADDR_DUR 16'h0200
`define ADDR_DUR_MIN 16'h0201
`define ADDR_DUR_MAX 16'h0202
`define ADDR_CUR 16'h0300
`define ADDR_CUR_MIN 16'h0301
`define ADDR_CUR_MAX 16'h0302
`define ADDR_CUR_MAX_LIM 16'h0306
`define ADDR_CUR_MEAS 16'h0307
`define ADDR_CUR_CAL 16'h030e
`define ADDR_VOLT_MEAS 16'h0407
`define ADDR_DRV_STATE 16'h0700
`define ADDR_SERIAL 16'h0701
`define ADDR_LOCK 16'h0800
`define ADDR_EXT_LOW 16'h0a05
`define ADDR_EXT_HIGH 16'h0a06
`define ADDR_COOL_T 16'h0a10
`define ADDR_COOL_T_MAX 16'h0a11
`define ADDR_COOL_T_MIN 16'h0a12
`define ADDR_COOL_T_MAX_LIM 16'h0a13
`define ADDR_COOL_T_MIN_LIM 16'h0a14
`define ADDR_COOL_T_MEAS 16'h0a15
`define ADDR_COOL_I_MEAS 16'h0a16
`define ADDR_COOL_I_LIM 16'h0a17
`define ADDR_COOL_V_MEAS 16'h0a18
`define ADDR_COOL_STATE 16'h0a1a
`define ADDR_COOL_CAL 16'h0a1e
`define ADDR_MOUNT_BETA 16'h0a1f
`define ADDR_EXT_MEAS 16'h0ae4
`define ADDR_EXT_BETA 16'h0b0e
// ----------------------------------------------------------------------
// State word commands
// ----------------------------------------------------------------------
`define CMD_START 16'h0008
`define CMD_STOP 16'h0010
`define CMD_INT_SET 16'h0020
`define CMD_EXT_SET 16'h0040
`define CMD_EXT_EN 16'h0200
`define CMD_INT_EN 16'h0400
`define CMD_ILK_ALLOW 16'h1000
`define CMD_ILK_DENY 16'h2000
`define CMD_EXT_ILK_DENY 16'h4000
`define CMD_EXT_ILK_ALLOW 16'h8000
// ----------------------------------------------------------------------
// Limits and reset values
// ----------------------------------------------------------------------
`define CAL_RESET 16'h2710
`define CAL_LO 16'h251c
`define CAL_HI 16'h2904
`define FREQ_MIN 16'h0000
`define FREQ_MAX 16'h2710
`define DUR_MIN 16'h0014
`define DUR_MAX 16'hc350
`define CUR_MIN 16'h0000
`define CUR_MAX_LIM 16'h1388
`define COOL_T_RESET 16'h09c4
`define COOL_T_MIN_LIM 16'h03e8
`define COOL_T_MAX_LIM 16'h1770
`define BETA_RESET 16'h0d7a
`define SERIAL_NUMBER 16'h0001
`endif

// ==== pump_map_pkg.sv ====
// Types carried between the parameter map and its neighbours.
// Assumes nothing of its surroundings.
package pump_map_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] param;
        logic [15:0] data;
    } req_t;
    typedef struct packed {
        logic valid;
        logic [15:0] param;
        logic [15:0] value;
    } resp_t;
    typedef struct packed {
        logic started;
        logic int_setpoint;
        logic int_enable;
    } unit_state_t;
    typedef struct packed {
        logic interlock;
        logic laser_overcurrent;
        logic laser_overheat;
        logic ext_thermistor;
        logic cooler_error;
        logic cooler_self_heat;
    } fault_t;
    typedef struct packed {
        logic [15:0] laser_current;
        logic [15:0] laser_voltage;
        logic [15:0] cooler_temp;
        logic [15:0] cooler_current;
        logic [15:0] cooler_voltage;
        logic [15:0] ext_thermistor_temp;
    } meas_t;
    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] duration;
        logic [15:0] current_setpoint;
        logic [15:0] current_max;
        logic [15:0] current_cal;
        logic [15:0] cooler_temp_setpoint;
        logic [15:0] cooler_temp_max;
        logic [15:0] cooler_temp_min;
        logic [15:0] cooler_current_limit;
        logic [15:0] cooler_cal;
        logic [15:0] ext_low;
        logic [15:0] ext_high;
        logic [15:0] mount_beta;
        logic [15:0] ext_beta;
        unit_state_t laser;
        unit_state_t cooler;
        logic main_ilk_deny;
        logic ext_ilk_deny;
    } settings_t;
endpackage : pump_map_pkg

// ==== limit_reg.sv ====
// One writable 16-bit parameter that clamps written values to a range.
// Assumes lo <= hi and a reset already synchronised to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module limit_reg #(
    parameter logic [15:0] RST = 16'h0000
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic [15:0] din,
    input wire logic [15:0] lo,
    input wire logic [15:0] hi,
    output logic [15:0] q
);
    // Out-of-range values round to the nearest limit
    wire logic below = din < lo;
    wire logic above = din > hi;
    wire logic [15:0] q_nxt = below ? lo : (above ? hi : din);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) q <= RST;
        else if (wr) q <= q_nxt;
    end
endmodule : limit_reg
`default_nettype wire

// ==== unit_state_ctl.sv ====
// Start/stop, setpoint source and enable source of one unit.
// Assumes trip comes from protection logic on clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "pump_map_cfg.svh"
module unit_state_ctl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic [15:0] din,
    input wire logic trip,
    output pump_map_pkg::unit_state_t st
);
    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    wire logic other = din != `CMD_START;
    wire logic is_start = din == `CMD_START;
    wire logic set_int = |(din & `CMD_INT_SET);
    wire logic set_ext = |(din & `CMD_EXT_SET);
    wire logic en_int = |(din & `CMD_INT_EN);
    wire logic en_ext = |(din & `CMD_EXT_EN);
    // External choice wins a conflicting pair: it is the power-on state
    wire logic int_set_nxt =
        set_ext ? 1'b0 : (set_int ? 1'b1 : st.int_setpoint);
    wire logic int_en_nxt = en_ext ? 1'b0 : (en_int ? 1'b1 : st.int_enable);
    // Start is refused under external enable or an active fault
    wire logic start_ok = is_start && st.int_enable && !trip;
    wire logic started_nxt = trip ? 1'b0 :
        (!wr ? st.started :
        (other ? 1'b0 : (start_ok ? 1'b1 : st.started)));
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st.started <= started_nxt;
            if (wr) begin
                st.int_setpoint <= int_set_nxt;
                st.int_enable <= int_en_nxt;
            end
        end
    end
endmodule : unit_state_ctl
`default_nettype wire

// ==== pump_map.sv ====
// Parameter map of the laser pump driver and cooler controller.
// Assumes a command parser on clk_sys issues one request at a time and
// that measurements and fault flags come from logic on clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "pump_map_cfg.svh"
// Summary of operation
// - Each parameter has a 16-bit number; read returns it, write sets the writable ones only.
// - Bit 0 of the driver state word always reads one.
// - State bits 1 started, 2 int set, 4 int enable; driver word only, 6 ext deny, 7 deny.
// - Driver state writes 1000h/2000h allow/deny main, 4000h/8000h deny/allow ext.
// - One interlock setting is shared by the laser driver and the cooler.
// - Calibrations reset to 2710h and stay within 251Ch to 2904h.
// - Laser setpoint calibration sits at 030E, readable and writable.
// - Parameter 0701 reads back the serial number and ignores writes.
// - Mount thermistor beta sits at 0A1F, readable and writable, in kelvin.
// - A read request is answered with the parameter number and its value.
// - Unknown parameters, read or written, answer number zero, value zero.
// - Any state command other than start stops the unit first.
module pump_map (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire pump_map_pkg::req_t req,
    input wire pump_map_pkg::meas_t meas,
    input wire pump_map_pkg::fault_t faults,
    output pump_map_pkg::resp_t resp,
    output pump_map_pkg::settings_t settings
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end
    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    wire logic wr = req.valid && req.write;
    wire logic we_freq = wr && req.param == `ADDR_FREQ;
    wire logic we_dur = wr && req.param == `ADDR_DUR;
    wire logic we_cur = wr && req.param == `ADDR_CUR;
    wire logic we_cur_max = wr && req.param == `ADDR_CUR_MAX;
    wire logic we_cur_cal = wr && req.param == `ADDR_CUR_CAL;
    wire logic we_drv_st = wr && req.param == `ADDR_DRV_STATE;
    wire logic we_ext_low = wr && req.param == `ADDR_EXT_LOW;
    wire logic we_ext_high = wr && req.param == `ADDR_EXT_HIGH;
    wire logic we_cool_t = wr && req.param == `ADDR_COOL_T;
    wire logic we_cool_max = wr && req.param == `ADDR_COOL_T_MAX;
    wire logic we_cool_min = wr && req.param == `ADDR_COOL_T_MIN;
    wire logic we_cool_ilim = wr && req.param == `ADDR_COOL_I_LIM;
    wire logic we_cool_st = wr && req.param == `ADDR_COOL_STATE;
    wire logic we_cool_cal = wr && req.param == `ADDR_COOL_CAL;
    wire logic we_mbeta = wr && req.param == `ADDR_MOUNT_BETA;
    wire logic we_ebeta = wr && req.param == `ADDR_EXT_BETA;
    // ------------------------------------------------------------------
    // Pulse and current parameters
    // ------------------------------------------------------------------
    logic [15:0] freq_q;
    logic [15:0] dur_q;
    logic [15:0] cur_q;
    logic [15:0] cur_max_q;
    logic [15:0] cur_cal_q;
    // Zero frequency stays legal: it selects continuous operation
    limit_reg #(.RST(`FREQ_MIN)) u_freq (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_freq),
        .din(req.data),
        .lo(`FREQ_MIN),
        .hi(`FREQ_MAX),
        .q(freq_q)
    );
    // Duration limit does not track the period; fixed window only
    limit_reg #(.RST(`DUR_MIN)) u_dur (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_dur),
        .din(req.data),
        .lo(`DUR_MIN),
        .hi(`DUR_MAX),
        .q(dur_q)
    );
    limit_reg #(.RST(`CUR_MIN)) u_cur (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_cur),
        .din(req.data),
        .lo(`CUR_MIN),
        .hi(cur_max_q),
        .q(cur_q)
    );
    limit_reg #(.RST(`CUR_MAX_LIM)) u_cur_max (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_cur_max),
        .din(req.data),
        .lo(`CUR_MIN),
        .hi(`CUR_MAX_LIM),
        .q(cur_max_q)
    );
    limit_reg #(.RST(`CAL_RESET)) u_cur_cal (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_cur_cal),
        .din(req.data),
        .lo(`CAL_LO),
        .hi(`CAL_HI),
        .q(cur_cal_q)
    );
    // ------------------------------------------------------------------
    // Cooler and thermistor parameters
    // ------------------------------------------------------------------
    logic [15:0] ext_low_q;
    logic [15:0] ext_high_q;
    logic [15:0] cool_t_q;
    logic [15:0] cool_max_q;
    logic [15:0] cool_min_q;
    logic [15:0] cool_ilim_q;
    logic [15:0] cool_cal_q;
    logic [15:0] mbeta_q;
    logic [15:0] ebeta_q;
    limit_reg #(.RST(16'h0000)) u_ext_low (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_ext_low),
        .din(req.data),
        .lo(16'h0000),
        .hi(16'hffff),
        .q(ext_low_q)
    );
    limit_reg #(.RST(16'hffff)) u_ext_high (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_ext_high),
        .din(req.data),
        .lo(16'h0000),
        .hi(16'hffff),
        .q(ext_high_q)
    );
    // Setpoint follows the user window, which sits inside the hard one
    limit_reg #(.RST(`COOL_T_RESET)) u_cool_t (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_cool_t),
        .din(req.data),
        .lo(cool_min_q),
        .hi(cool_max_q),
        .q(cool_t_q)
    );
    limit_reg #(.RST(`COOL_T_MAX_LIM)) u_cool_max (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_cool_max),
        .din(req.data),
        .lo(`COOL_T_MIN_LIM),
        .hi(`COOL_T_MAX_LIM),
        .q(cool_max_q)
    );
    limit_reg #(.RST(`COOL_T_MIN_LIM)) u_cool_min (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_cool_min),
        .din(req.data),
        .lo(`COOL_T_MIN_LIM),
        .hi(`COOL_T_MAX_LIM),
        .q(cool_min_q)
    );
    limit_reg #(.RST(16'hffff)) u_cool_ilim (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_cool_ilim),
        .din(req.data),
        .lo(16'h0000),
        .hi(16'hffff),
        .q(cool_ilim_q)
    );
    limit_reg #(.RST(`CAL_RESET)) u_cool_cal (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_cool_cal),
        .din(req.data),
        .lo(`CAL_LO),
        .hi(`CAL_HI),
        .q(cool_cal_q)
    );
    limit_reg #(.RST(`BETA_RESET)) u_mbeta (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_mbeta),
        .din(req.data),
        .lo(16'h0000),
        .hi(16'hffff),
        .q(mbeta_q)
    );
    limit_reg #(.RST(`BETA_RESET)) u_ebeta (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_ebeta),
        .din(req.data),
        .lo(16'h0000),
        .hi(16'hffff),
        .q(ebeta_q)
    );
    // ------------------------------------------------------------------
    // Shared interlock settings
    // ------------------------------------------------------------------
    logic ilk_deny_r;
    logic ext_deny_r;
    // Deny wins a conflicting pair, the safer reading
    wire logic ilk_deny_nxt = |(req.data & `CMD_ILK_DENY) ? 1'b1 :
        (|(req.data & `CMD_ILK_ALLOW) ? 1'b0 : ilk_deny_r);
    wire logic ext_deny_nxt = |(req.data & `CMD_EXT_ILK_DENY) ? 1'b1 :
        (|(req.data & `CMD_EXT_ILK_ALLOW) ? 1'b0 : ext_deny_r);
    // One copy only: cooler state writes do not reach it
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ilk_deny_r <= 1'b0;
            ext_deny_r <= 1'b0;
        end else if (we_drv_st) begin
            ilk_deny_r <= ilk_deny_nxt;
            ext_deny_r <= ext_deny_nxt;
        end
    end
    // ------------------------------------------------------------------
    // Unit states
    // ------------------------------------------------------------------
    wire logic ilk_trip = faults.interlock && !ilk_deny_r;
    wire logic laser_trip = ilk_trip ||
        (faults.ext_thermistor && !ext_deny_r) ||
        faults.laser_overcurrent || faults.laser_overheat;
    wire logic cooler_trip = ilk_trip || faults.cooler_error ||
        faults.cooler_self_heat;
    pump_map_pkg::unit_state_t laser_st;
    pump_map_pkg::unit_state_t cooler_st;
    unit_state_ctl u_laser_st (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_drv_st),
        .din(req.data),
        .trip(laser_trip),
        .st(laser_st)
    );
    unit_state_ctl u_cooler_st (
        .clk_sys(clk_sys),
        .rst_n(rst_n_r),
        .wr(we_cool_st),
        .din(req.data),
        .trip(cooler_trip),
        .st(cooler_st)
    );
    // ------------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------------
    wire logic [15:0] drv_word = {8'h00, ilk_deny_r, ext_deny_r, 1'b0,
        laser_st.int_enable, 1'b0, laser_st.int_setpoint,
        laser_st.started, 1'b1};
    wire logic [15:0] cool_word = {11'h000, cooler_st.int_enable, 1'b0,
        cooler_st.int_setpoint, cooler_st.started, 1'b0};
    wire logic [15:0] lock_word = {8'h00, faults.cooler_self_heat,
        faults.cooler_error, faults.ext_thermistor,
        faults.laser_overheat, faults.laser_overcurrent, 1'b0,
        faults.interlock, 1'b0};
    // ------------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------------
    logic [15:0] rd_val;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (req.param)
            `ADDR_FREQ: rd_val = freq_q;
            `ADDR_FREQ_MIN: rd_val = `FREQ_MIN;
            `ADDR_FREQ_MAX: rd_val = `FREQ_MAX;
            `ADDR_DUR: rd_val = dur_q;
            `ADDR_DUR_MIN: rd_val = `DUR_MIN;
            `ADDR_DUR_MAX: rd_val = `DUR_MAX;
            `ADDR_CUR: rd_val = cur_q;
            `ADDR_CUR_MIN: rd_val = `CUR_MIN;
            `ADDR_CUR_MAX: rd_val = cur_max_q;
            `ADDR_CUR_MAX_LIM: rd_val = `CUR_MAX_LIM;
            `ADDR_CUR_MEAS: rd_val = meas.laser_current;
            `ADDR_CUR_CAL: rd_val = cur_cal_q;
            `ADDR_VOLT_MEAS: rd_val = meas.laser_voltage;
            `ADDR_DRV_STATE: rd_val = drv_word;
            `ADDR_SERIAL: rd_val = `SERIAL_NUMBER;
            `ADDR_LOCK: rd_val = lock_word;
            `ADDR_EXT_LOW: rd_val = ext_low_q;
            `ADDR_EXT_HIGH: rd_val = ext_high_q;
            `ADDR_COOL_T: rd_val = cool_t_q;
            `ADDR_COOL_T_MAX: rd_val = cool_max_q;
            `ADDR_COOL_T_MIN: rd_val = cool_min_q;
            `ADDR_COOL_T_MAX_LIM: rd_val = `COOL_T_MAX_LIM;
            `ADDR_COOL_T_MIN_LIM: rd_val = `COOL_T_MIN_LIM;
            `ADDR_COOL_T_MEAS: rd_val = meas.cooler_temp;
            `ADDR_COOL_I_MEAS: rd_val = meas.cooler_current;
            `ADDR_COOL_I_LIM: rd_val = cool_ilim_q;
            `ADDR_COOL_V_MEAS: rd_val = meas.cooler_voltage;
            `ADDR_COOL_STATE: rd_val = cool_word;
            `ADDR_COOL_CAL: rd_val = cool_cal_q;
            `ADDR_MOUNT_BETA: rd_val = mbeta_q;
            `ADDR_EXT_MEAS: rd_val = meas.ext_thermistor_temp;
            `ADDR_EXT_BETA: rd_val = ebeta_q;
            default: begin
                rd_hit = 1'b0;
                rd_val = 16'h0000;
            end
        endcase
    end
    // ------------------------------------------------------------------
    // Response
    // ------------------------------------------------------------------
    // Known writes stay silent; unknown ones still get the null answer
    wire logic resp_go = req.valid && (!req.write || !rd_hit);
    pump_map_pkg::resp_t resp_nxt;
    assign resp_nxt.valid = resp_go;
    assign resp_nxt.param = rd_hit ? req.param : 16'h0000;
    assign resp_nxt.value = rd_hit ? rd_val : 16'h0000;
    pump_map_pkg::resp_t resp_r;
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) resp_r <= '0;
        else resp_r <= resp_nxt;
    end
    assign resp = resp_r;
    // ------------------------------------------------------------------
    // Settings towards the analogue side
    // ------------------------------------------------------------------
    assign settings.freq = freq_q;
    assign settings.duration = dur_q;
    assign settings.current_setpoint = cur_q;
    assign settings.current_max = cur_max_q;
    assign settings.current_cal = cur_cal_q;
    assign settings.cooler_temp_setpoint = cool_t_q;
    assign settings.cooler_temp_max = cool_max_q;
    assign settings.cooler_temp_min = cool_min_q;
    assign settings.cooler_current_limit = cool_ilim_q;
    assign settings.cooler_cal = cool_cal_q;
    assign settings.ext_low = ext_low_q;
    assign settings.ext_high = ext_high_q;
    assign settings.mount_beta = mbeta_q;
    assign settings.ext_beta = ebeta_q;
    assign settings.laser = laser_st;
    assign settings.cooler = cooler_st;
    assign settings.main_ilk_deny = ilk_deny_r;
    assign settings.ext_ilk_deny = ext_deny_r;
endmodule : pump_map
`default_nettype wire

// ==== pump_map_chk.sv ====
// Checker of answers and settings of the parameter map.
// Assumes a bind onto the ports of pump_map.
`timescale 1ns/10ps
`default_nettype none
module pump_map_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire pump_map_pkg::req_t req,
    input wire pump_map_pkg::meas_t meas,
    input wire pump_map_pkg::fault_t faults,
    input wire pump_map_pkg::resp_t resp,
    input wire pump_map_pkg::settings_t settings
);
    wire logic rd = req.valid && !req.write;
    wire logic sw = req.valid && req.write && req.param == 16'h0700;
    wire logic rs = rd && req.param == 16'h0700;
    wire logic on = settings.laser.started;
    wire logic [1:0] dn = {settings.main_ilk_deny, settings.ext_ilk_deny};
    wire logic [15:0] cal = settings.current_cal;
    wire logic [15:0] lk = {8'h00, faults.cooler_self_heat,
        faults.cooler_error, faults.ext_thermistor, faults.laser_overheat,
        faults.laser_overcurrent, 1'b0, faults.interlock, 1'b0};
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    property p_ans; rd |=> resp.valid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_unk; req.valid && req.param > 16'h0fff |=>
        resp.valid && {resp.param, resp.value} == 32'h0; endproperty
    a_unk: assert property (p_unk) else $error("bad unknown");
    property p_pwr; rs |=> resp.param == 16'h0700 && resp.value[0];
    endproperty
    a_pwr: assert property (p_pwr) else $error("power bit");
    property p_bits; rs |=> resp.value[7:6] == $past(dn) &&
        resp.value[1] == $past(on); endproperty
    a_bits: assert property (p_bits) else $error("state bits");
    property p_cal; cal >= 16'h251c && cal <= 16'h2904; endproperty
    a_cal: assert property (p_cal) else $error("cal range");
    property p_deny; sw && req.data[13] |=> dn[1]; endproperty
    a_deny: assert property (p_deny) else $error("deny lost");
    property p_stop; sw && req.data != 16'h0008 |=> !on; endproperty
    a_stop: assert property (p_stop) else $error("not stopped");
    property p_lock; rd && req.param == 16'h0800 |=> resp.value == $past(lk);
    endproperty
    a_lock: assert property (p_lock) else $error("lock word");
    c_rs: cover property (rs);
    c_sw: cover property (sw);
    c_unk: cover property (req.valid && req.param > 16'h0fff);
endmodule : pump_map_chk
bind pump_map pump_map_chk chk_i (.clk_sys(clk_sys), .rstn(rstn),
    .req(req), .meas(meas), .faults(faults), .resp(resp),
    .settings(settings));
`default_nettype wire

// ==== pump_map_host.sv ====
// Host model: one request at a time, answer collected.
// Assumes clk_sys from the bench; drives at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module pump_map_host (
    input wire logic clk_sys,
    input wire pump_map_pkg::resp_t resp,
    output pump_map_pkg::req_t req
);
    initial req = '0;
    task automatic xfer(input logic w, input logic [15:0] p, d,
                        output logic [32:0] r);
        r = '0;
        @(negedge clk_sys);
        req = '{1'b1, w, p, d};
        repeat (2) begin
            @(negedge clk_sys);
            // Released lines inverted so stale values never pass
            req = '{1'b0, w, ~p, ~d};
            if (resp.valid === 1'b1) r = {1'b1, resp.param, resp.value};
        end
    endtask : xfer
endmodule : pump_map_host
`default_nettype wire

// ==== pump_driver_parameter_map_test.sv ====
// Self-checking bench of the parameter map.
// Assumes design, checker and host model compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "pump_map_cfg.svh"
module pump_driver_parameter_map_test;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    pump_map_pkg::req_t req;
    pump_map_pkg::resp_t resp;
    pump_map_pkg::meas_t meas = '0;
    pump_map_pkg::fault_t faults = '0;
    integer fails = 0;
    integer check_count = 0;
    integer cycles = 0;
    integer seed = 49;
    logic [32:0] r;
    logic [15:0] d;
    pump_map_pkg::settings_t sets;
    logic [15:0] corner [4] = '{16'h0000, 16'h251c, 16'h2904, 16'hffff};
    // Command, then expected state word
    logic [31:0] seq [14] = '{32'h0008_0001, 32'h0400_0011, 32'h0008_0013,
        32'h0010_0011, 32'h0008_0013, 32'h0000_0011, 32'h0008_0013,
        32'h0020_0015, 32'h0040_0011, 32'h0200_0001, 32'h2000_0081,
        32'h4000_00c1, 32'h1000_0041, 32'h8000_0001};
    always #5 clk_sys = ~clk_sys;
    pump_map dut (.clk_sys(clk_sys), .rstn(rstn), .req(req), .meas(meas),
        .faults(faults), .resp(resp), .settings(sets));
    pump_map_host host (.clk_sys(clk_sys), .resp(resp), .req(req));
    function automatic logic [15:0] clamp(logic [15:0] v, lo, hi);
        return v < lo ? lo : (v > hi ? hi : v);
    endfunction : clamp
    function automatic logic [15:0] lock_exp(pump_map_pkg::fault_t f);
        return {8'h00, f.cooler_self_heat, f.cooler_error, f.ext_thermistor,
            f.laser_overheat, f.laser_overcurrent, 1'b0, f.interlock, 1'b0};
    endfunction : lock_exp
    task automatic chk(input logic [32:0] got, exp);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask : chk
    task automatic rd(input logic [15:0] p, exp);
        host.xfer(1'b0, p, 16'h0000, r);
        chk(r, {1'b1, p, exp});
    endtask : rd
    task automatic wr(input logic [15:0] p, v);
        host.xfer(1'b1, p, v, r);
        chk(r, 33'h0);
    endtask : wr
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            report_and_stop;
        end
    end
    initial begin
        repeat (12) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        rd(`ADDR_DRV_STATE, 16'h0001);
        rd(`ADDR_CUR_CAL, `CAL_RESET);
        rd(`ADDR_COOL_CAL, `CAL_RESET);
        wr(`ADDR_SERIAL, 16'h5a5a);
        rd(`ADDR_SERIAL, `SERIAL_NUMBER);
        wr(`ADDR_DUR_MAX, 16'h0001);
        rd(`ADDR_DUR_MAX, `DUR_MAX);
        for (int i = 0; i < 16; i++) begin
            d = 16'($random(seed));
            if (i < 4) d = corner[i];
            wr(`ADDR_CUR_CAL, d);
            rd(`ADDR_CUR_CAL, clamp(d, `CAL_LO, `CAL_HI));
            wr(`ADDR_MOUNT_BETA, d);
            rd(`ADDR_MOUNT_BETA, d);
            chk(33'(sets.mount_beta), 33'(d));
            wr(`ADDR_FREQ, d);
            rd(`ADDR_FREQ, clamp(d, `FREQ_MIN, `FREQ_MAX));
            wr(`ADDR_DUR, d);
            rd(`ADDR_DUR, clamp(d, `DUR_MIN, `DUR_MAX));
            faults = 6'($random(seed));
            rd(`ADDR_LOCK, lock_exp(faults));
            meas.laser_current = d;
            rd(`ADDR_CUR_MEAS, d);
            host.xfer(d[12], {4'h1, d[11:0]}, d, r);
            chk(r, {1'b1, 32'h0});
        end
        faults = '0;
        for (int i = 0; i < 14; i++) begin
            wr(`ADDR_DRV_STATE, seq[i][31:16]);
            rd(`ADDR_DRV_STATE, seq[i][15:0]);
            chk(33'(sets.laser.started), 33'(seq[i][1]));
        end
        // Cooler kept running only while the shared deny holds
        wr(`ADDR_DRV_STATE, `CMD_ILK_DENY);
        faults.interlock = 1'b1;
        wr(`ADDR_COOL_STATE, `CMD_INT_EN);
        wr(`ADDR_COOL_STATE, `CMD_START);
        rd(`ADDR_COOL_STATE, 16'h0012);
        wr(`ADDR_DRV_STATE, `CMD_ILK_ALLOW);
        rd(`ADDR_COOL_STATE, 16'h0010);
        chk(33'(sets.cooler.started), 33'h0);
        wr(`ADDR_COOL_STATE, `CMD_INT_SET | `CMD_EXT_EN);
        rd(`ADDR_COOL_STATE, 16'h0004);
        report_and_stop;
    end
endmodule : pump_driver_parameter_map_test
`default_nettype wire
